// File: rtl/pad_sync.sv
// two-flop synchroniser for a group of pad inputs
`timescale 1ns/1ps
`default_nettype none
module pad_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = d_i;
        s_nxt.stable = s_r.meta;
    end

    // registers, preset high: pads idle under their reset pull-ups,
    // so no false slave select or false edge on q_o follows reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.stable;

endmodule
`default_nettype wire

// File: rtl/pin_mux_pkg.sv
// pin indices, config bit positions and reset values for the pin group
//
// Notes on behaviour
// R1: after reset every pin selects its primary peripheral, not the port function
// R2: port E pull-up bits 4 to 7 control the four SPI 0 pin pull-ups
// R3: port C bit 7 controls home 0 pull-up, bit 0 the phase A 1
// R4: SPI 1 clock reaches the phase A 1 pin only with alt select set
// R5: each pin in port mode has its own input or output direction
// R6: SPI 0 clock pad drives in master mode, is the clock input in slave
// R7: master-out pad drives in master mode and is an input in slave mode
// R8: master-in pad drives only in slave mode and only when the slave is selected
// R9: slave select input tells a slave that the current transfer is to be received
// R10: alt select clear keeps decoder input and leaves SPI 1 clock unconnected
package pin_mux_pkg;

    // ------------------------------------------------------------------
    // pin indices within the group
    // ------------------------------------------------------------------
    localparam int NUM_PINS      = 6;
    localparam int PIN_DEC0_HOME = 0;
    localparam int PIN_SPI0_CLK  = 1;
    localparam int PIN_SPI0_MOSI = 2;
    localparam int PIN_SPI0_MISO = 3;
    localparam int PIN_SPI0_SEL  = 4;
    localparam int PIN_PHA1      = 5;

    // ------------------------------------------------------------------
    // pull-up register bit positions
    // ------------------------------------------------------------------
    localparam int PUE_WIDTH       = 8;
    localparam int PUE_E_SPI0_CLK  = 4;
    localparam int PUE_E_SPI0_MOSI = 5;
    localparam int PUE_E_SPI0_MISO = 6;
    localparam int PUE_E_SPI0_SEL  = 7;
    localparam int PUE_C_DEC0_HOME = 7;
    localparam int PUE_C_PHA1      = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [NUM_PINS-1:0]  GPIO_SEL_RST = 6'h00;
    localparam logic [NUM_PINS-1:0]  GPIO_DIR_RST = 6'h00;
    localparam logic [PUE_WIDTH-1:0] PUE_RST      = 8'hff;
    localparam logic                 ALT_RST      = 1'b0;
    localparam logic [NUM_PINS-1:0]  ALL_INPUT    = 6'h3f;
    localparam logic [NUM_PINS-1:0]  ALL_ZERO     = 6'h00;

    // ------------------------------------------------------------------
    // state of the mux
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0]  gpio_sel;
        logic [NUM_PINS-1:0]  gpio_dir;
        logic [PUE_WIDTH-1:0] pue_c;
        logic [PUE_WIDTH-1:0] pue_e;
        logic                 alt;
        logic [NUM_PINS-1:0]  pad_out;
        logic [NUM_PINS-1:0]  pad_oe_n;
        logic [NUM_PINS-1:0]  pull_en;
        logic [NUM_PINS-1:0]  gpio_in;
        logic                 dec0_home;
        logic                 spi0_clk_in;
        logic                 spi0_mosi_in;
        logic                 spi0_miso_in;
        logic                 spi0_sel_n;
        logic                 pha1;
        logic                 spi1_clk_in;
    } mux_state_t;

endpackage

// File: rtl/spi_decoder_pin_mux.sv
// pin function mux and pad control for the SPI 0 / decoder pin group
`timescale 1ns/1ps
`default_nettype none
module spi_decoder_pin_mux
    import pin_mux_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    // configuration, taken on cfg_load_i
    input  wire logic                 cfg_load_i,
    input  wire logic [NUM_PINS-1:0]  gpio_mode_i,
    input  wire logic [NUM_PINS-1:0]  gpio_dir_i,
    input  wire logic [PUE_WIDTH-1:0] port_c_pullup_enable_i,
    input  wire logic [PUE_WIDTH-1:0] port_e_pullup_enable_i,
    input  wire logic                 phase_a_alt_select_i,
    // port data
    input  wire logic [NUM_PINS-1:0]  gpio_out_i,
    output logic      [NUM_PINS-1:0]  gpio_in_o,
    // SPI 0 core side
    input  wire logic                 spi0_master_i,
    input  wire logic                 spi0_sclk_out_i,
    input  wire logic                 spi0_mosi_out_i,
    input  wire logic                 spi0_miso_out_i,
    output logic                      spi0_serial_clock_o,
    output logic                      spi0_master_out_data_o,
    output logic                      spi0_master_in_data_o,
    output logic                      spi0_slave_select_n_o,
    // SPI 1 clock core side
    input  wire logic                 spi1_master_i,
    input  wire logic                 spi1_sclk_out_i,
    output logic                      spi1_serial_clock_o,
    // decoder side
    output logic                      decoder0_home_in_o,
    output logic                      decoder1_phase_a_in_o,
    // pads
    input  wire logic [NUM_PINS-1:0]  pad_i,
    output logic      [NUM_PINS-1:0]  pad_o,
    output logic      [NUM_PINS-1:0]  pad_oe_n_o,
    output logic      [NUM_PINS-1:0]  pullup_en_o
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    // asynchronous assert, two-flop release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // pad input synchroniser
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] pad_sy;

    pad_sync #(
        .WIDTH (NUM_PINS)
    ) u_pad_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (pad_i),
        .q_o     (pad_sy)
    );

    // ------------------------------------------------------------------
    // mux state
    // ------------------------------------------------------------------
    mux_state_t s_r;
    mux_state_t s_nxt;
    logic       spi0_selected;

    // slave select is active low, only while the pin is in SPI use
    assign spi0_selected = !s_r.gpio_sel[PIN_SPI0_SEL]
                           && !pad_sy[PIN_SPI0_SEL];

    // next state: config load, pad drive and peripheral routing
    always_comb begin
        s_nxt = s_r;
        // config register, primary functions after reset
        if (cfg_load_i) begin
            s_nxt.gpio_sel = gpio_mode_i;
            s_nxt.gpio_dir = gpio_dir_i;
            s_nxt.pue_c    = port_c_pullup_enable_i;
            s_nxt.pue_e    = port_e_pullup_enable_i;
            s_nxt.alt      = phase_a_alt_select_i;
        end
        // pull-up map, clearing a bit disables the pull-up
        s_nxt.pull_en[PIN_SPI0_CLK]  = s_r.pue_e[PUE_E_SPI0_CLK];  // R2
        s_nxt.pull_en[PIN_SPI0_MOSI] = s_r.pue_e[PUE_E_SPI0_MOSI]; // R2
        s_nxt.pull_en[PIN_SPI0_MISO] = s_r.pue_e[PUE_E_SPI0_MISO]; // R2
        s_nxt.pull_en[PIN_SPI0_SEL]  = s_r.pue_e[PUE_E_SPI0_SEL];  // R2
        s_nxt.pull_en[PIN_DEC0_HOME] = s_r.pue_c[PUE_C_DEC0_HOME]; // R3
        s_nxt.pull_en[PIN_PHA1]      = s_r.pue_c[PUE_C_PHA1];      // R3
        // primary functions: all inputs unless a role drives
        s_nxt.pad_out  = ALL_ZERO;
        s_nxt.pad_oe_n = ALL_INPUT; // R1
        // clock pad follows master or slave role
        if (spi0_master_i) begin
            s_nxt.pad_out[PIN_SPI0_CLK]  = spi0_sclk_out_i;
            s_nxt.pad_oe_n[PIN_SPI0_CLK] = 1'b0; // R6
        end
        // master-out pad drives in master mode only
        if (spi0_master_i) begin
            s_nxt.pad_out[PIN_SPI0_MOSI]  = spi0_mosi_out_i;
            s_nxt.pad_oe_n[PIN_SPI0_MOSI] = 1'b0; // R7
        end
        // master-in pad: selected slave drives, else high impedance
        if (!spi0_master_i && spi0_selected) begin
            s_nxt.pad_out[PIN_SPI0_MISO]  = spi0_miso_out_i;
            s_nxt.pad_oe_n[PIN_SPI0_MISO] = 1'b0; // R8
        end
        // SPI 1 clock onto phase A 1 pin only under alt select
        if (s_r.alt && spi1_master_i) begin
            s_nxt.pad_out[PIN_PHA1]  = spi1_sclk_out_i; // R4
            s_nxt.pad_oe_n[PIN_PHA1] = 1'b0;
        end
        // port mode overrides per pin with its own direction
        for (int i = 0; i < NUM_PINS; i++) begin
            if (s_r.gpio_sel[i]) begin
                s_nxt.pad_out[i]  = s_r.gpio_dir[i] && gpio_out_i[i];
                s_nxt.pad_oe_n[i] = !s_r.gpio_dir[i]; // R5
            end
        end
        // port input readback
        s_nxt.gpio_in = pad_sy;
        // peripheral inputs, idle when the pin is elsewhere
        s_nxt.dec0_home    = !s_r.gpio_sel[PIN_DEC0_HOME]
                             && pad_sy[PIN_DEC0_HOME];
        s_nxt.spi0_clk_in  = !s_r.gpio_sel[PIN_SPI0_CLK] && !spi0_master_i
                             && pad_sy[PIN_SPI0_CLK]; // R6
        s_nxt.spi0_mosi_in = !s_r.gpio_sel[PIN_SPI0_MOSI] && !spi0_master_i
                             && pad_sy[PIN_SPI0_MOSI]; // R7
        s_nxt.spi0_miso_in = !s_r.gpio_sel[PIN_SPI0_MISO] && spi0_master_i
                             && pad_sy[PIN_SPI0_MISO]; // R8
        s_nxt.spi0_sel_n   = !spi0_selected; // R9
        // alt select clear keeps the decoder, SPI 1 gets nothing
        s_nxt.pha1         = !s_r.gpio_sel[PIN_PHA1] && !s_r.alt
                             && pad_sy[PIN_PHA1]; // R10
        s_nxt.spi1_clk_in  = !s_r.gpio_sel[PIN_PHA1] && s_r.alt
                             && !spi1_master_i && pad_sy[PIN_PHA1]; // R10
    end

    // state register with reset defaults
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.gpio_sel <= GPIO_SEL_RST; // R1
            s_r.gpio_dir <= GPIO_DIR_RST;
            s_r.pue_c    <= PUE_RST;
            s_r.pue_e    <= PUE_RST;
            s_r.alt      <= ALT_RST;
            s_r.pad_oe_n <= ALL_INPUT;
            s_r.pull_en  <= ALL_INPUT;
            s_r.spi0_sel_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign pad_o                  = s_r.pad_out;
    assign pad_oe_n_o             = s_r.pad_oe_n;
    assign pullup_en_o            = s_r.pull_en;
    assign gpio_in_o              = s_r.gpio_in;
    assign decoder0_home_in_o     = s_r.dec0_home;
    assign spi0_serial_clock_o    = s_r.spi0_clk_in;
    assign spi0_master_out_data_o = s_r.spi0_mosi_in;
    assign spi0_master_in_data_o  = s_r.spi0_miso_in;
    assign spi0_slave_select_n_o  = s_r.spi0_sel_n;
    assign decoder1_phase_a_in_o  = s_r.pha1;
    assign spi1_serial_clock_o    = s_r.spi1_clk_in;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_reset_primary: assert property ( // R1
        @(posedge clk_i) $rose(rst_n) |->
            (pad_oe_n_o == ALL_INPUT) && (s_r.gpio_sel == ALL_ZERO)
            ##1 ($past(cfg_load_i) || (s_r.gpio_sel == ALL_ZERO)))
        else $error("pins not in primary input state after reset");

    chk_pue_e_map: assert property ( // R2
        @(posedge clk_i) disable iff (!rst_n)
        cfg_load_i |-> ##2
            (pullup_en_o[PIN_SPI0_CLK]
                == $past(port_e_pullup_enable_i[PUE_E_SPI0_CLK], 2))
            && (pullup_en_o[PIN_SPI0_SEL]
                == $past(port_e_pullup_enable_i[PUE_E_SPI0_SEL], 2)))
        else $error("port E pull-up bit not mapped to SPI 0 pad");

    chk_pue_c_map: assert property ( // R3
        @(posedge clk_i) disable iff (!rst_n)
        cfg_load_i |-> ##2
            (pullup_en_o[PIN_DEC0_HOME]
                == $past(port_c_pullup_enable_i[PUE_C_DEC0_HOME], 2))
            && (pullup_en_o[PIN_PHA1]
                == $past(port_c_pullup_enable_i[PUE_C_PHA1], 2)))
        else $error("port C pull-up bit not mapped to its pad");

    chk_spi1_clk_route: assert property ( // R4
        @(posedge clk_i) disable iff (!rst_n)
        (!s_r.alt && !s_r.gpio_sel[PIN_PHA1]) |=> pad_oe_n_o[PIN_PHA1])
        else $error("phase A 1 pad driven without alt select");

    chk_alt_clear: assert property ( // R10
        @(posedge clk_i) disable iff (!rst_n)
        !s_r.alt |=> !spi1_serial_clock_o
            && (decoder1_phase_a_in_o == ($past(pad_sy[PIN_PHA1])
                && !$past(s_r.gpio_sel[PIN_PHA1]))))
        else $error("alt clear did not keep decoder function");

    chk_gpio_dir: assert property ( // R5
        @(posedge clk_i) disable iff (!rst_n)
        s_r.gpio_sel[PIN_DEC0_HOME] |=>
            pad_oe_n_o[PIN_DEC0_HOME] == !$past(s_r.gpio_dir[PIN_DEC0_HOME]))
        else $error("port mode direction not applied");

    chk_spi0_clk_dir: assert property ( // R6
        @(posedge clk_i) disable iff (!rst_n)
        !s_r.gpio_sel[PIN_SPI0_CLK] |=>
            pad_oe_n_o[PIN_SPI0_CLK] == !$past(spi0_master_i))
        else $error("SPI 0 clock pad direction wrong for role");

    chk_spi0_mosi_dir: assert property ( // R7
        @(posedge clk_i) disable iff (!rst_n)
        (!s_r.gpio_sel[PIN_SPI0_MOSI] && spi0_master_i) |=>
            !pad_oe_n_o[PIN_SPI0_MOSI]
            && (pad_o[PIN_SPI0_MOSI] == $past(spi0_mosi_out_i)))
        else $error("master-out pad not driven in master mode");

    chk_spi0_miso_hiz: assert property ( // R8
        @(posedge clk_i) disable iff (!rst_n)
        (!s_r.gpio_sel[PIN_SPI0_MISO] && (spi0_master_i || !spi0_selected))
            |=> pad_oe_n_o[PIN_SPI0_MISO])
        else $error("master-in pad driven while master or unselected");

    chk_spi0_sel_pass: assert property ( // R9
        @(posedge clk_i) disable iff (!rst_n)
        !s_r.gpio_sel[PIN_SPI0_SEL] |=>
            spi0_slave_select_n_o == $past(pad_sy[PIN_SPI0_SEL]))
        else $error("slave select not passed to SPI 0");

endmodule
`default_nettype wire

// File: testbench/spi_peer_model.sv
// far-side peer: drives the lines it owns and resolves each pad wire
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model
    import pin_mux_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [NUM_PINS-1:0] dev_out_i,
    input  wire logic [NUM_PINS-1:0] dev_oe_n_i,
    input  wire logic [NUM_PINS-1:0] pull_i,
    input  wire logic [NUM_PINS-1:0] drv_i,
    input  wire logic [NUM_PINS-1:0] val_i,
    output logic      [NUM_PINS-1:0] level_o
);
    logic [NUM_PINS-1:0] last_r;

    // wire level: device drive, else peer drive, else pull or drift
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!dev_oe_n_i[i]) begin
                level_o[i] = dev_out_i[i];
            end else if (drv_i[i]) begin
                level_o[i] = val_i[i];
            end else if (pull_i[i]) begin
                level_o[i] = 1'h1;
            end else begin
                level_o[i] = ~last_r[i]; // floating line never holds
            end
        end
    end

    // remember the last level so a released line can drift
    always_ff @(posedge clk_i) begin
        last_r <= level_o;
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the SPI 0 / decoder pin mux
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pin_mux_pkg::*;
    logic                clk_i = 1'h0;
    logic                nrst_i = 1'h0;
    logic                ld = 1'h0, alt = 1'h0, m0 = 1'h0, m1 = 1'h0;
    logic                sck0 = 1'h0, mo0 = 1'h0, mi0 = 1'h0, sck1 = 1'h0;
    logic [NUM_PINS-1:0] mode = 6'h00, dir = 6'h00, gout = 6'h00;
    logic [NUM_PINS-1:0] drv = 6'h00, val = 6'h00;
    logic [7:0]          pc = 8'hff, pe = 8'hff;
    logic [NUM_PINS-1:0] gin, lvl, pad_o, oe_n, pull;
    logic                sck_in, mo_in, mi_in, ss_n, sck1_in, home, pha;
    int                  err_total = 0;
    int                  total_checks = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    spi_decoder_pin_mux spi_decoder_pin_mux_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .cfg_load_i(ld),
        .gpio_mode_i(mode), .gpio_dir_i(dir),
        .port_c_pullup_enable_i(pc), .port_e_pullup_enable_i(pe),
        .phase_a_alt_select_i(alt), .gpio_out_i(gout), .gpio_in_o(gin),
        .spi0_master_i(m0), .spi0_sclk_out_i(sck0),
        .spi0_mosi_out_i(mo0), .spi0_miso_out_i(mi0),
        .spi0_serial_clock_o(sck_in), .spi0_master_out_data_o(mo_in),
        .spi0_master_in_data_o(mi_in), .spi0_slave_select_n_o(ss_n),
        .spi1_master_i(m1), .spi1_sclk_out_i(sck1),
        .spi1_serial_clock_o(sck1_in), .decoder0_home_in_o(home),
        .decoder1_phase_a_in_o(pha), .pad_i(lvl), .pad_o(pad_o),
        .pad_oe_n_o(oe_n), .pullup_en_o(pull));

    spi_peer_model spi_peer_model_i (
        .clk_i(clk_i), .dev_out_i(pad_o), .dev_oe_n_i(oe_n),
        .pull_i(pull), .drv_i(drv), .val_i(val), .level_o(lvl));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic load(input logic [5:0] md, input logic [5:0] dr,
                        input logic [7:0] c, input logic [7:0] e,
                        input logic a);
        mode = md;
        dir = dr;
        pc = c;
        pe = e;
        alt = a;
        ld = 1'h1;
        cyc(1);
        ld = 1'h0;
        cyc(5);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_primary;
        drv = 6'h31;
        val = 6'h31;
        cyc(5);
        check("home", home, 8'h01);
        check("phase_a", pha, 8'h01);
        check("spi1_clk", sck1_in, 8'h00);
        check("oe_n", oe_n, 8'h3f);
        val = 6'h10;
        cyc(5);
        check("home", home, 8'h00);
        check("phase_a", pha, 8'h00);
        $display("test primary done");
    endtask

    task automatic t_pull;
        logic [7:0] cs [2] = '{8'h7f, 8'h80};
        logic [7:0] es [2] = '{8'h50, 8'haf};
        for (int k = 0; k < 2; k++) begin
            load(6'h00, 6'h00, cs[k], es[k], 1'h0);
            check("pull", pull, {cs[k][0], es[k][7:4], cs[k][7]});
        end
        $display("test pull done");
    endtask

    task automatic t_gpio;
        logic [5:0] ds [2] = '{6'h2a, 6'h15};
        drv = 6'h00;
        gout = 6'h33;
        for (int k = 0; k < 2; k++) begin
            load(6'h3f, ds[k], 8'hff, 8'hff, 1'h0);
            check("oe_n", oe_n, ds[k] ^ ALL_INPUT);
            check("pad_o", pad_o, ds[k] & gout);
            check("gin", gin, (ds[k] & gout) | (ds[k] ^ ALL_INPUT));
        end
        $display("test gpio done");
    endtask

    task automatic t_master;
        load(6'h00, 6'h00, 8'hff, 8'hff, 1'h0);
        m0 = 1'h1;
        drv = 6'h08;
        for (int v = 0; v < 2; v++) begin
            sck0 = v[0];
            mo0 = ~v[0];
            val = {2'h0, ~v[0], 3'h0};
            cyc(5);
            check("oe_n", oe_n, 8'h39);
            check("sclk_pad", pad_o[1], v[0]);
            check("mosi_pad", pad_o[2], !v[0]);
            check("miso_in", mi_in, !v[0]);
            check("sclk_in", sck_in, 8'h00);
        end
        $display("test master done");
    endtask

    task automatic t_slave;
        m0 = 1'h0;
        drv = 6'h16;
        for (int v = 0; v < 3; v++) begin
            val = {1'h0, v == 2, 1'h0, ~v[0], v[0], 1'h0};
            mi0 = ~v[0];
            cyc(5);
            check("ss_n", ss_n, v == 2);
            check("miso_oe", oe_n[3], v == 2);
            check("mosi_oe", oe_n[2], 8'h01);
            if (v < 2) begin
                check("miso_pad", pad_o[3], !v[0]);
                check("sclk_in", sck_in, v[0]);
                check("mosi_in", mo_in, !v[0]);
            end
        end
        $display("test slave done");
    endtask

    task automatic t_alt;
        m1 = 1'h1;
        sck1 = 1'h1;
        drv = 6'h20;
        val = 6'h20;
        load(6'h00, 6'h00, 8'hff, 8'hff, 1'h0);
        check("pa_oe", oe_n[5], 8'h01);
        check("phase_a", pha, 8'h01);
        check("spi1_clk", sck1_in, 8'h00);
        drv = 6'h00;
        load(6'h00, 6'h00, 8'hff, 8'hff, 1'h1);
        check("pa_oe", oe_n[5], 8'h00);
        check("pa_pad", pad_o[5], 8'h01);
        m1 = 1'h0;
        drv = 6'h20;
        cyc(5);
        check("spi1_clk", sck1_in, 8'h01);
        check("phase_a", pha, 8'h00);
        $display("test alt done");
    endtask

    // main sequence: reset for 4 cycles, then every scenario
    initial begin
        cyc(4);
        check("oe_n_rst", oe_n, 8'h3f);
        check("pull_rst", pull, 8'h3f);
        check("ss_n_rst", ss_n, 8'h01);
        nrst_i = 1'h1;
        cyc(3);
        // first edge out of reset: no false select, nothing driven
        check("oe_n_rel", oe_n, 8'h3f);
        check("ss_n_rel", ss_n, 8'h01);
        t_primary();
        t_pull();
        t_gpio();
        t_master();
        t_slave();
        t_alt();
        give_verdict();
    end

    // watchdog against a hang
    initial begin
        cyc(2000);
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
